// file: include/imu_params.svh
`ifndef IMU_PARAMS_SVH
`define IMU_PARAMS_SVH

// Register widths
`define IMU_XLEN        64
`define IMU_WORD        32
`define IMU_REG_ADDR_W  5
// Default latency in cycles (whole product formed at issue, then held until the count runs out)
`define IMU_LATENCY     4
// Reset value of the result pair
`define IMU_PAIR_RESET  64'h0000000000000000

`endif

// file: include/imu_pkg.sv
`include "imu_params.svh"

package imu_pkg;

	// Operation codes presented with an issue
	typedef enum logic [2:0] {
		IMU_OP_NONE      = 3'h0,
		IMU_OP_MUL_REG   = 3'h1, // signed_multiply_to_register
		IMU_OP_MUL_PAIR  = 3'h2, // signed_multiply_to_pair
		IMU_OP_MULU_PAIR = 3'h3, // unsigned_multiply_to_pair
		IMU_OP_MOVE_HIGH = 3'h4  // move_to_high_result
	} imu_op_t;

	// Issue bundle from the pipeline
	typedef struct packed {
		logic                         valid;
		imu_op_t                      op;
		logic [`IMU_XLEN-1:0]         first_source;
		logic [`IMU_XLEN-1:0]         second_source;
		logic [`IMU_REG_ADDR_W-1:0]   dest;
	} imu_issue_t;

	// Write to the general register file
	typedef struct packed {
		logic                         valid;
		logic [`IMU_REG_ADDR_W-1:0]   dest;
		logic [`IMU_XLEN-1:0]         data;
	} imu_gpr_wr_t;

	// One-hot unit state
	typedef enum logic [1:0] {
		IMU_ST_IDLE = 2'b01,
		IMU_ST_BUSY = 2'b10
	} imu_state_t;

endpackage : imu_pkg

// file: rtl/imu_multiply_unit.sv
`timescale 1ns/1ps
`include "imu_params.svh"

module imu_multiply_unit #(
	parameter int LATENCY = `IMU_LATENCY
) (
	input  wire logic                        sys_clk_in,
	input  wire logic                        srst_in,
	input  wire imu_pkg::imu_issue_t         issue_in,
	input  wire logic                        gpr_read_valid_in,
	input  wire logic [`IMU_REG_ADDR_W-1:0]  gpr_read_addr_in,
	input  wire logic                        pair_read_valid_in,
	output logic                             issue_ready_out,
	output logic                             gpr_read_stall_out,
	output logic                             pair_read_stall_out,
	output imu_pkg::imu_gpr_wr_t             gpr_write_out,
	output logic [`IMU_XLEN-1:0]             high_result_out,
	output logic [`IMU_XLEN-1:0]             low_result_out,
	output logic                             reg_pending_out,
	output logic                             pair_pending_out,
	output logic                             exception_out
);

	localparam int CNT_W = $clog2(LATENCY + 1);

	// Elaboration check on latency
	if (LATENCY < 1 || LATENCY > 64) begin : g_bad_latency
		$error("LATENCY must lie between 1 and 64");
	end

	////////////////////////////////////////////////////////////////////////////
	// State
	imu_pkg::imu_state_t            state_reg, state_next;
	logic [CNT_W-1:0]               count_reg, count_next;
	logic                           to_pair_reg, to_pair_next;
	logic [`IMU_REG_ADDR_W-1:0]     dest_reg, dest_next;
	logic [`IMU_XLEN-1:0]           hi_reg, hi_next;
	logic [`IMU_XLEN-1:0]           lo_reg, lo_next;
	logic signed [65:0]             prod_reg, prod_next;
	imu_pkg::imu_gpr_wr_t           wr_reg, wr_next;
	logic                           reg_pend_reg, reg_pend_next;
	logic                           pair_pend_reg, pair_pend_next;

	logic                           busy;
	logic                           is_mul_op;
	logic signed [32:0]             opa;
	logic signed [32:0]             opb;
	logic                           done;

	assign busy      = (state_reg == imu_pkg::IMU_ST_BUSY);
	assign is_mul_op = issue_in.valid && (issue_in.op == imu_pkg::IMU_OP_MUL_REG ||
		issue_in.op == imu_pkg::IMU_OP_MUL_PAIR || issue_in.op == imu_pkg::IMU_OP_MULU_PAIR);
	assign done      = busy && (count_reg == CNT_W'(1));

	// Operand extension: unsigned zero-extends, signed sign-extends the low word; upper bits ignored
	always_comb begin
		if (issue_in.op == imu_pkg::IMU_OP_MULU_PAIR) begin
			opa = {1'b0, issue_in.first_source[31:0]};
			opb = {1'b0, issue_in.second_source[31:0]};
		end else begin
			opa = {issue_in.first_source[31], issue_in.first_source[31:0]};
			opb = {issue_in.second_source[31], issue_in.second_source[31:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic for the multiply sequencer and result registers
	always_comb begin
		state_next     = state_reg;
		count_next     = count_reg;
		to_pair_next   = to_pair_reg;
		dest_next      = dest_reg;
		hi_next        = hi_reg;
		lo_next        = lo_reg;
		prod_next      = prod_reg;
		wr_next        = '0;
		reg_pend_next  = reg_pend_reg;
		pair_pend_next = pair_pend_reg;
		case (state_reg)
			imu_pkg::IMU_ST_IDLE: begin
				if (is_mul_op) begin
					// Product captured at issue, held while the latency runs out
					prod_next      = opa * opb;
					count_next     = CNT_W'(LATENCY);
					dest_next      = issue_in.dest;
					to_pair_next   = (issue_in.op != imu_pkg::IMU_OP_MUL_REG);
					state_next     = imu_pkg::IMU_ST_BUSY;
					reg_pend_next  = (issue_in.op == imu_pkg::IMU_OP_MUL_REG);
					pair_pend_next = (issue_in.op != imu_pkg::IMU_OP_MUL_REG);
				end else if (issue_in.valid && issue_in.op == imu_pkg::IMU_OP_MOVE_HIGH) begin
					hi_next = issue_in.first_source;
				end
			end
			imu_pkg::IMU_ST_BUSY: begin
				count_next = count_reg - CNT_W'(1);
				if (done) begin
					state_next = imu_pkg::IMU_ST_IDLE;
					if (to_pair_reg) begin
						// Each word sign-extended into its register
						lo_next        = {{32{prod_reg[31]}}, prod_reg[31:0]};
						hi_next        = {{32{prod_reg[63]}}, prod_reg[63:32]};
						pair_pend_next = 1'b0;
					end else begin
						wr_next.valid = 1'b1;
						wr_next.dest  = dest_reg;
						wr_next.data  = {{32{prod_reg[31]}}, prod_reg[31:0]};
						reg_pend_next = 1'b0;
					end
				end
			end
			default: begin
				state_next = imu_pkg::IMU_ST_IDLE;
			end
		endcase
	end

	// Register stage
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			state_reg     <= imu_pkg::IMU_ST_IDLE;
			count_reg     <= '0;
			to_pair_reg   <= 1'b0;
			dest_reg      <= '0;
			hi_reg        <= `IMU_PAIR_RESET;
			lo_reg        <= `IMU_PAIR_RESET;
			prod_reg      <= '0;
			wr_reg        <= '0;
			reg_pend_reg  <= 1'b0;
			pair_pend_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			count_reg     <= count_next;
			to_pair_reg   <= to_pair_next;
			dest_reg      <= dest_next;
			hi_reg        <= hi_next;
			lo_reg        <= lo_next;
			prod_reg      <= prod_next;
			wr_reg        <= wr_next;
			reg_pend_reg  <= reg_pend_next;
			pair_pend_reg <= pair_pend_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interlocks and outputs; issue_ready_out is low, so no new issue is taken, while busy
	assign issue_ready_out     = !busy;
	assign gpr_read_stall_out  = gpr_read_valid_in && reg_pend_reg &&
		(gpr_read_addr_in == dest_reg);
	assign pair_read_stall_out = pair_read_valid_in && pair_pend_reg;
	assign gpr_write_out       = wr_reg;
	assign high_result_out     = hi_reg; // Pair reads are combinational: a following write is safe
	assign low_result_out      = lo_reg;
	assign reg_pending_out     = reg_pend_reg;
	assign pair_pending_out    = pair_pend_reg;
	assign exception_out       = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	logic [6:0] busy_cnt_reg;
	always_ff @(posedge sys_clk_in) begin
		if (srst_in || !busy) begin
			busy_cnt_reg <= '0;
		end else begin
			busy_cnt_reg <= busy_cnt_reg + 7'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checker reference: full 64-bit product worked out apart from the datapath
	logic [63:0]                    chk_sa;
	logic [63:0]                    chk_sb;
	logic [63:0]                    chk_prod;
	logic [63:0]                    exp_wr_reg, exp_wr_next;
	logic [63:0]                    exp_lo_reg, exp_lo_next;
	logic [63:0]                    exp_hi_reg, exp_hi_next;

	// Operands widened to 64 bits; low 64 bits of the product are sign-agnostic
	always_comb begin
		if (issue_in.op == imu_pkg::IMU_OP_MULU_PAIR) begin
			chk_sa = {32'h00000000, issue_in.first_source[31:0]};
			chk_sb = {32'h00000000, issue_in.second_source[31:0]};
		end else begin
			chk_sa = {{32{issue_in.first_source[31]}}, issue_in.first_source[31:0]};
			chk_sb = {{32{issue_in.second_source[31]}}, issue_in.second_source[31:0]};
		end
		chk_prod = chk_sa * chk_sb;
	end

	// Expected results, captured when a multiply is taken
	always_comb begin
		exp_wr_next = exp_wr_reg;
		exp_lo_next = exp_lo_reg;
		exp_hi_next = exp_hi_reg;
		if (!busy && is_mul_op) begin
			exp_wr_next = {{32{chk_prod[31]}}, chk_prod[31:0]};
			exp_lo_next = {{32{chk_prod[31]}}, chk_prod[31:0]};
			exp_hi_next = {{32{chk_prod[63]}}, chk_prod[63:32]};
		end
	end

	// Expected result registers
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			exp_wr_reg <= 64'h0000000000000000;
			exp_lo_reg <= 64'h0000000000000000;
			exp_hi_reg <= 64'h0000000000000000;
		end else begin
			exp_wr_reg <= exp_wr_next;
			exp_lo_reg <= exp_lo_next;
			exp_hi_reg <= exp_hi_next;
		end
	end

	// Register multiply: write arrives LATENCY+1 edges after the issue edge
	a_reg_mul_timing: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(state_reg == imu_pkg::IMU_ST_IDLE && issue_in.valid && issue_in.op == imu_pkg::IMU_OP_MUL_REG)
		|-> ##(LATENCY + 1) gpr_write_out.valid)
		else $error("register multiply result late");

	// Register multiply: written data is the sign-extended low product word
	a_reg_mul_value: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		gpr_write_out.valid |-> (gpr_write_out.data == exp_wr_reg))
		else $error("register multiply result wrong");

	// Write pulse lasts one cycle and carries the captured destination
	a_write_pulse: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		gpr_write_out.valid |-> (gpr_write_out.dest == dest_reg) ##1 !gpr_write_out.valid)
		else $error("register write pulse wrong");

	// Pair result against the independently formed product
	a_pair_value: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(done && to_pair_reg) |=> (lo_reg == exp_lo_reg && hi_reg == exp_hi_reg))
		else $error("pair result value wrong");

	// Pending flag falls exactly when the register write is launched
	a_pend_write: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		$fell(reg_pend_reg) |-> gpr_write_out.valid)
		else $error("pending flag fell without write");

	// At most one kind of multiply outstanding
	a_pend_onehot: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		!(reg_pend_reg && pair_pend_reg))
		else $error("both pending flags set");

	// No stall of an unrelated register or of an idle pair
	a_no_false_stall: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(gpr_read_addr_in != dest_reg || !pair_pend_reg) |->
		((gpr_read_addr_in == dest_reg || !gpr_read_stall_out) && (pair_pend_reg || !pair_read_stall_out)))
		else $error("stall without pending result");

	// Unit is ready again right after completion
	a_ready_after: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		done |=> issue_ready_out)
		else $error("unit not ready after completion");

	a_pair_untouched: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(busy && !to_pair_reg) |=> ($stable(hi_reg) && $stable(lo_reg)))
		else $error("register multiply changed result pair");

	a_no_exception: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		!exception_out)
		else $error("multiply raised exception");

	a_pair_words: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(done && to_pair_reg) |=> (lo_reg[31:0] == $past(prod_reg[31:0]) && hi_reg[31:0] == $past(prod_reg[63:32])
		&& lo_reg[63:32] == {32{lo_reg[31]}} && hi_reg[63:32] == {32{hi_reg[31]}}))
		else $error("pair result words wrong");

	a_unsigned_ext: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(issue_in.op == imu_pkg::IMU_OP_MULU_PAIR) |-> (opa[32] == 1'b0 && opb[32] == 1'b0))
		else $error("unsigned operand not zero-extended");

	a_gpr_stall: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(gpr_read_valid_in && gpr_read_addr_in == dest_reg && busy && !to_pair_reg) |-> gpr_read_stall_out)
		else $error("destination read not stalled");

	a_pair_stall: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(pair_read_valid_in && busy && to_pair_reg) |-> pair_read_stall_out)
		else $error("pair read not stalled");

	a_busy_bound: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		busy_cnt_reg <= 7'(LATENCY))
		else $error("multiply ran past its latency");

	a_move_high: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(!busy && issue_in.valid && issue_in.op == imu_pkg::IMU_OP_MOVE_HIGH) |=> hi_reg == $past(issue_in.first_source))
		else $error("move to high wrong");

	// Pending set the cycle after issue, cleared LATENCY cycles later
	a_pend_clear: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(!busy && is_mul_op) |=> (reg_pend_reg || pair_pend_reg) ##(LATENCY) !(reg_pend_reg || pair_pend_reg))
		else $error("pending flag timing wrong");

endmodule : imu_multiply_unit

// file: verif/imu_pipe_model.sv
`timescale 1ns/1ps
`include "imu_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Pipeline issue stage: holds each request until the unit takes it
module imu_pipe_model (
	input  wire logic                sys_clk_in,
	input  wire logic                srst_in,
	input  wire imu_pkg::imu_issue_t req_in,
	input  wire logic                issue_ready_in,
	output imu_pkg::imu_issue_t      issue_out
);
	imu_pkg::imu_issue_t issue_reg;
	imu_pkg::imu_issue_t issue_next;
	logic                swap;

	// Next issue; released operands are inverted so stale values never pass for live ones
	always_comb begin
		issue_next = issue_reg;
		swap = req_in.op != imu_pkg::IMU_OP_MOVE_HIGH
			&& req_in.first_source[31:0] < req_in.second_source[31:0];
		if (issue_reg.valid && issue_ready_in) begin
			issue_next.valid = 1'h0;
			issue_next.first_source = ~issue_reg.first_source;
			issue_next.second_source = ~issue_reg.second_source;
		end else if (!issue_reg.valid && req_in.valid) begin
			issue_next = req_in;
			if (swap) begin
				issue_next.first_source = req_in.second_source;
				issue_next.second_source = req_in.first_source;
			end
		end
	end

	// Issue register
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			issue_reg <= '0;
		end else begin
			issue_reg <= issue_next;
		end
	end

	assign issue_out = issue_reg;
endmodule : imu_pipe_model

// file: verif/integer_multiply_unit_tb_top.sv
`timescale 1ns/1ps
`include "imu_params.svh"

////////////////////////////////////////////////////////////////////////////////
module integer_multiply_unit_tb_top;
	localparam int LAT = 3;
	logic                 sys_clk_in, srst_in, gpr_read_valid_in, pair_read_valid_in;
	logic [4:0]           gpr_read_addr_in;
	logic                 issue_ready_out, gpr_read_stall_out, pair_read_stall_out;
	logic                 reg_pending_out, pair_pending_out, exception_out;
	imu_pkg::imu_issue_t  req, issue;
	imu_pkg::imu_gpr_wr_t gpr_write_out;
	logic [63:0]          high_result_out, low_result_out, exp_hi, exp_lo, exp_rd;
	logic [63:0]          vals [4];
	integer               error_cnt, n_compared, seed;

	imu_pipe_model u_pipe (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .req_in(req),
		.issue_ready_in(issue_ready_out), .issue_out(issue));
	imu_multiply_unit #(.LATENCY(LAT)) u_dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .issue_in(issue),
		.gpr_read_valid_in(gpr_read_valid_in), .gpr_read_addr_in(gpr_read_addr_in),
		.pair_read_valid_in(pair_read_valid_in), .issue_ready_out(issue_ready_out),
		.gpr_read_stall_out(gpr_read_stall_out), .pair_read_stall_out(pair_read_stall_out),
		.gpr_write_out(gpr_write_out), .high_result_out(high_result_out), .low_result_out(low_result_out),
		.reg_pending_out(reg_pending_out), .pair_pending_out(pair_pending_out), .exception_out(exception_out));

	// Clock, 40 ns period
	initial begin
		sys_clk_in = 1'h0;
		forever #20 sys_clk_in = ~sys_clk_in;
	end

	// Counts one comparison and reports a mismatch
	task automatic chk(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'h1) begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic results;
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	// One operation through the pipeline model, with reference update and interlock checks
	task automatic run(input imu_pkg::imu_op_t op, input logic [63:0] a, input logic [63:0] b, input logic [4:0] d);
		logic [63:0] p;
		logic        pr, took, done;
		int          n;
		pr = op inside {imu_pkg::IMU_OP_MUL_PAIR, imu_pkg::IMU_OP_MULU_PAIR};
		took = 1'h0;
		done = 1'h0;
		p = (op == imu_pkg::IMU_OP_MULU_PAIR) ? {32'h0, a[31:0]} * {32'h0, b[31:0]}
			: 64'($signed(a[31:0])) * 64'($signed(b[31:0]));
		if (op == imu_pkg::IMU_OP_MUL_REG) exp_rd = {{32{p[31]}}, p[31:0]};
		if (pr) exp_lo = {{32{p[31]}}, p[31:0]};
		if (pr) exp_hi = {{32{p[63]}}, p[63:32]};
		if (op == imu_pkg::IMU_OP_MOVE_HIGH) exp_hi = a;
		@(posedge sys_clk_in);
		req <= '{1'h1, op, a, b, d};
		@(posedge sys_clk_in);
		req.valid <= 1'h0;
		for (n = 0; n < 60 && !done; n++) begin
			@(posedge sys_clk_in);
			gpr_read_valid_in <= 1'($random(seed));
			gpr_read_addr_in <= d ^ 5'($random(seed) & 1);
			pair_read_valid_in <= 1'($random(seed));
			#1;
			took = took || issue.valid === 1'h0;
			done = took && (op == imu_pkg::IMU_OP_MUL_REG ? gpr_write_out.valid === 1'h1
				: !pr || pair_pending_out === 1'h0);
			chk(exception_out === 1'h0, "exception raised");
			if (took && !done)
				chk(reg_pending_out === !pr && pair_pending_out === pr && issue_ready_out === 1'h0
					&& gpr_read_stall_out === (gpr_read_valid_in && gpr_read_addr_in == d && !pr)
					&& pair_read_stall_out === (pair_read_valid_in && pr), "interlock");
		end
		if (!done) begin
			chk(1'h0, "operation never completed");
			results;
		end
		if (op == imu_pkg::IMU_OP_MUL_REG)
			chk(gpr_write_out.data === exp_rd && gpr_write_out.dest === d, "register result");
		chk(high_result_out === exp_hi && low_result_out === exp_lo, "result pair");
	endtask : run

	// Reset, boundary operands for every operation, then random traffic
	initial begin
		srst_in = 1'h1;
		req = '0;
		gpr_read_valid_in = 1'h0;
		pair_read_valid_in = 1'h0;
		gpr_read_addr_in = 5'h0;
		error_cnt = 0;
		n_compared = 0;
		seed = 44;
		exp_hi = 64'h0;
		exp_lo = 64'h0;
		vals = '{64'hFFFFFFFF80000000, 64'hFFFFFFFFFFFFFFFF, 64'h000000007FFFFFFF, 64'h0000000000000003};
		repeat (2) @(posedge sys_clk_in);
		srst_in <= 1'h0;
		#1;
		chk(issue_ready_out === 1'h1 && high_result_out === 64'h0 && gpr_write_out.valid === 1'h0, "reset state");
		for (int k = 1; k < 5; k++)
			for (int i = 0; i < 4; i++)
				run(imu_pkg::imu_op_t'(3'(k)), vals[i], vals[(i + k) % 4], 5'(i + k));
		for (int i = 0; i < 40; i++)
			run(imu_pkg::imu_op_t'(3'(1 + ($random(seed) & 3))), {$random(seed), $random(seed)},
				{$random(seed), $random(seed)}, 5'($random(seed)));
		results;
	end
endmodule : integer_multiply_unit_tb_top
